// file: hw/fsws_latches.sv
// Purpose: bank of 14-bit write latches
// Assumes: index is the low address bits, always inside the row
// Notes: blank restores every latch at once
`timescale 1ns/1ns
`default_nettype none
module fsws_latches
  import fsws_pkg::*;
#(
  parameter int LATCHES = FSWS_LATCHES,
  parameter int IDX_BITS = FSWS_LATCH_BITS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [IDX_BITS-1:0] idx,
  input wire logic [13:0] wdata,
  input wire logic blank,
  input wire logic [IDX_BITS-1:0] rd_idx,
  output logic [13:0] rd_data
);

  logic [13:0] mem_q [LATCHES];
  logic [13:0] mem_d [LATCHES];

  // ==========================================================
  // latch update
  always_comb begin
    for (int i = 0; i < LATCHES; i++) begin
      mem_d[i] = mem_q[i];
      if (blank) begin
        mem_d[i] = FSWS_BLANK_WORD; // RULE_10
      end else if (load && idx == IDX_BITS'(i)) begin
        mem_d[i] = wdata; // RULE_09
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < LATCHES; i++) begin
      if (rst) begin
        mem_q[i] <= FSWS_BLANK_WORD;
      end else begin
        mem_q[i] <= mem_d[i];
      end
    end
  end

  assign rd_data = mem_q[rd_idx];

endmodule : fsws_latches
`default_nettype wire

// file: hw/fsws_pkg.sv
// Purpose: shared constants and types of the flash self-write sequencer
// Assumes: 100 MHz CLK, classic Wishbone register access, 32-bit data
// Notes: registers take one aligned word each; narrower data sits low
package fsws_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] FSWS_ADDR_LOW_OFS = 8'h00;
  localparam logic [7:0] FSWS_ADDR_HIGH_OFS = 8'h04;
  localparam logic [7:0] FSWS_DATA_LOW_OFS = 8'h08;
  localparam logic [7:0] FSWS_DATA_HIGH_OFS = 8'h0c;
  localparam logic [7:0] FSWS_CONTROL_OFS = 8'h10;
  localparam logic [7:0] FSWS_UNLOCK_OFS = 8'h14;

  // ==========================================================
  // control register fields
  localparam int FSWS_START_BIT = 0;
  localparam int FSWS_WRITE_ENABLE_BIT = 2;
  localparam int FSWS_ERR_BIT = 3;
  localparam int FSWS_LATCH_ONLY_BIT = 5;
  localparam int FSWS_ERASE_BIT = 4;
  localparam int FSWS_CONFIG_SPACE_SELECT_BIT = 6;

  // ==========================================================
  // values
  localparam logic [7:0] FSWS_UNLOCK_FIRST = 8'h55;
  localparam logic [7:0] FSWS_UNLOCK_SECOND = 8'haa;
  localparam logic [13:0] FSWS_BLANK_WORD = 14'h3fff;
  localparam logic [7:0] FSWS_ADDR_HIGH_RESET = 8'h80;
  localparam int FSWS_ROW_BITS = 10;
  localparam int FSWS_LATCH_BITS = 5;
  localparam int FSWS_LATCHES = 32;

  // ==========================================================
  // timing
  localparam int FSWS_CLK_MHZ = 100;
  localparam int FSWS_SETUP_CYCLES = 2;
  localparam int FSWS_ERASE_TIME_US = 2000;
  localparam int FSWS_ERASE_CYCLES = FSWS_ERASE_TIME_US * FSWS_CLK_MHZ;
  localparam int FSWS_PROG_TIME_US = 2000;
  localparam int FSWS_PROG_CYCLES = FSWS_PROG_TIME_US * FSWS_CLK_MHZ;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } fsws_wb_req_type;

  typedef struct packed {
    logic erase;
    logic prog;
    logic [FSWS_ROW_BITS-1:0] row;
  } fsws_flash_cmd_type;

  typedef enum logic [3:0] {
    FSWS_IDLE = 4'b0001,
    FSWS_SETUP = 4'b0010,
    FSWS_BUSY = 4'b0100,
    FSWS_CLEAN = 4'b1000
  } fsws_state_type;

endpackage : fsws_pkg

// file: hw/fsws_top.sv
// Purpose: self-write sequencer for on-chip program flash
// Assumes: Wishbone classic slave; flash array has no done signal on its port
// Notes: timing counts stand in for the array's own write timer
//
// Functional notes
// [RULE_01] erase while running is a whole row only
// [RULE_02] software erase: address, clear config select, erase, enable, unlock, start
// [RULE_03] two setup cycles after start; software places two no-operations
// [RULE_04] erase stalls the processor about 2 ms; clocks keep running
// [RULE_05] after erase resume at third instruction after start
// [RULE_06] programming never erases; software ensures target words are blank
// [RULE_07] one programming writes up to the 32 latch words
// [RULE_08] upper ten address bits pick the row; lower five pick latch
// [RULE_09] loads and programming stay in the addressed row
// [RULE_10] all latches return to 0x3fff after every program or erase
// [RULE_11] latch-only set: unlock plus start only loads the addressed latch
// [RULE_12] latch-only clear: load last latch then program whole row
// [RULE_13] a broken unlock pattern starts nothing
// [RULE_14] software programs by loading latches then clearing latch-only last
// [RULE_15] programming stalls after the two setup cycles until done
// [RULE_16] latch load forces two setup cycles then no stall
// [RULE_17] start bit is set by software only, cleared by hardware
// [RULE_18] reset during a write sets the error flag, kept after reset
// [RULE_19] unlock register is write-only and reads as zero
// [RULE_20] unlock arms on 55h then aah back to back; start consumes it
// [RULE_21] software masks interrupts around the unlock pattern
//
// The register addresses and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module fsws_top
  import fsws_pkg::*;
#(
  parameter int ERASE_CYCLES = FSWS_ERASE_CYCLES,
  parameter int PROG_CYCLES = FSWS_PROG_CYCLES
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic CPU_STALL,
  output logic FLASH_ERASE,
  output logic FLASH_PROGRAM,
  output logic [FSWS_ROW_BITS-1:0] FLASH_ROW,
  output logic [FSWS_LATCH_BITS-1:0] FLASH_LATCH_IDX,
  output logic [13:0] FLASH_LATCH_DATA
);

  localparam int CNT_W = 32;

  fsws_wb_req_type req;
  fsws_state_type state_q, state_d;
  logic [7:0] addr_low_q, addr_low_d, addr_high_q, addr_high_d;
  logic [7:0] data_low_q, data_low_d;
  logic [5:0] data_high_q, data_high_d;
  logic start_q, start_d, write_enable_q, write_enable_d, err_q, err_d;
  logic latch_only_q, latch_only_d, erase_q, erase_d, config_space_select_q, config_space_select_d;
  logic is_erase_q, is_erase_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic ack_q, ack_d, stall_q, stall_d;
  logic [31:0] rdat_q, rdat_d;
  fsws_flash_cmd_type cmd_q, cmd_d;
  logic acc, wr_acc, start_req, armed, consume, latch_load, blank;
  logic [13:0] latch_rd;

  // true when the byte lane 0 is written at the given offset
  function automatic logic hit(input fsws_wb_req_type r, input logic [7:0] ofs);
    hit = r.we && r.sel[0] && r.adr == ofs;
  endfunction : hit

  assign req = '{cyc: WB_CYC_I, stb: WB_STB_I, we: WB_WE_I, adr: WB_ADR_I,
                 sel: WB_SEL_I, dat: WB_DAT_I};
  // one access per request: ack drops the cycle after it was given
  assign acc = req.cyc && req.stb && !ack_q;
  assign wr_acc = acc && req.we;
  assign start_req = acc && hit(req, FSWS_CONTROL_OFS) && req.dat[FSWS_START_BIT]
                     && !start_q;
  // any start request consumes the unlock, even one that is refused
  assign consume = start_req;
  assign latch_load = state_q == FSWS_SETUP && cnt_q == '0 && !is_erase_q; // RULE_11
  assign blank = state_q == FSWS_CLEAN; // RULE_10

  // ==========================================================
  // unlock detection
  fsws_unlock u_unlock (
    .clk(CLK),
    .rst(RST),
    .acc(acc && !start_req),
    .unlock_wr(wr_acc && hit(req, FSWS_UNLOCK_OFS)),
    .wdata(req.dat[7:0]),
    .consume(consume),
    .armed(armed)
  );

  // ==========================================================
  // write latches
  fsws_latches #(
    .LATCHES(FSWS_LATCHES),
    .IDX_BITS(FSWS_LATCH_BITS)
  ) u_latches (
    .clk(CLK),
    .rst(RST),
    .load(latch_load),
    .idx(addr_low_q[FSWS_LATCH_BITS-1:0]), // RULE_08
    .wdata({data_high_q, data_low_q}),
    .blank(blank),
    .rd_idx(cmd_q.prog ? FLASH_LATCH_IDX : '0),
    .rd_data(latch_rd)
  );

  // ==========================================================
  // registers and bus
  always_comb begin
    addr_low_d = addr_low_q;
    addr_high_d = addr_high_q;
    data_low_d = data_low_q;
    data_high_d = data_high_q;
    write_enable_d = write_enable_q;
    latch_only_d = latch_only_q;
    erase_d = erase_q;
    config_space_select_d = config_space_select_q;
    err_d = err_q;
    ack_d = acc;
    rdat_d = '0;
    if (wr_acc && req.sel[0]) begin
      case (req.adr)
        FSWS_ADDR_LOW_OFS: addr_low_d = req.dat[7:0];
        FSWS_ADDR_HIGH_OFS: addr_high_d = {1'b1, req.dat[6:0]};
        FSWS_DATA_LOW_OFS: data_low_d = req.dat[7:0];
        FSWS_DATA_HIGH_OFS: data_high_d = req.dat[5:0];
        FSWS_CONTROL_OFS: begin
          write_enable_d = req.dat[FSWS_WRITE_ENABLE_BIT];
          latch_only_d = req.dat[FSWS_LATCH_ONLY_BIT];
          erase_d = req.dat[FSWS_ERASE_BIT];
          config_space_select_d = req.dat[FSWS_CONFIG_SPACE_SELECT_BIT];
          err_d = req.dat[FSWS_ERR_BIT];
        end
        default: ;
      endcase
    end
    if (acc && !req.we) begin
      case (req.adr)
        FSWS_ADDR_LOW_OFS: rdat_d = {24'h0, addr_low_q};
        FSWS_ADDR_HIGH_OFS: rdat_d = {24'h0, addr_high_q};
        FSWS_DATA_LOW_OFS: rdat_d = {24'h0, data_low_q};
        FSWS_DATA_HIGH_OFS: rdat_d = {26'h0, data_high_q};
        FSWS_CONTROL_OFS: rdat_d = {24'h0, 1'b0, config_space_select_q, latch_only_q, erase_q, err_q,
                                    write_enable_q, 1'b0, start_q};
        FSWS_UNLOCK_OFS: rdat_d = '0; // RULE_19
        default: rdat_d = '0;
      endcase
    end
  end

  // ==========================================================
  // sequencer
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    start_d = start_q;
    is_erase_d = is_erase_q;
    stall_d = stall_q;
    cmd_d = cmd_q;
    case (state_q)
      FSWS_IDLE: begin
        // a start without unlock or enable does nothing
        // judged on the word written with start, so one write may select and start
        if (start_req && armed && write_enable_d && !config_space_select_d) begin // RULE_13
          start_d = 1'b1; // RULE_17
          is_erase_d = erase_d;
          cnt_d = CNT_W'(FSWS_SETUP_CYCLES - 1);
          stall_d = 1'b1; // RULE_03
          state_d = FSWS_SETUP;
        end
      end
      FSWS_SETUP: begin
        if (cnt_q != '0) begin
          cnt_d = cnt_q - 1'b1;
        end else if (!is_erase_q && latch_only_q) begin
          start_d = 1'b0;
          stall_d = 1'b0; // RULE_16
          state_d = FSWS_IDLE;
        end else begin
          cmd_d.row = {addr_high_q[6:0], addr_low_q[7:5]}; // RULE_08
          cmd_d.erase = is_erase_q; // RULE_01
          cmd_d.prog = !is_erase_q; // RULE_12
          cnt_d = is_erase_q ? CNT_W'(ERASE_CYCLES - 1) : CNT_W'(PROG_CYCLES - 1);
          state_d = FSWS_BUSY; // RULE_04
        end
      end
      FSWS_BUSY: begin
        // programming only writes latch contents; no erase is implied
        if (cnt_q != '0) begin // RULE_15
          cnt_d = cnt_q - 1'b1;
        end else begin
          cmd_d.erase = 1'b0;
          cmd_d.prog = 1'b0; // RULE_06
          state_d = FSWS_CLEAN;
        end
      end
      FSWS_CLEAN: begin
        start_d = 1'b0; // RULE_17
        stall_d = 1'b0; // RULE_05
        state_d = FSWS_IDLE;
      end
      default: state_d = FSWS_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      // a reset that cuts a write short leaves its mark
      err_q <= err_q | start_q; // RULE_18
      state_q <= FSWS_IDLE;
      cnt_q <= '0;
      start_q <= 1'b0;
      is_erase_q <= 1'b0;
      stall_q <= 1'b0;
      cmd_q <= '0;
      addr_low_q <= '0;
      addr_high_q <= FSWS_ADDR_HIGH_RESET;
      data_low_q <= '0;
      data_high_q <= '0;
      write_enable_q <= 1'b0;
      latch_only_q <= 1'b0;
      erase_q <= 1'b0;
      config_space_select_q <= 1'b0;
      ack_q <= 1'b0;
      rdat_q <= '0;
    end else begin
      err_q <= err_d;
      state_q <= state_d;
      cnt_q <= cnt_d;
      start_q <= start_d;
      is_erase_q <= is_erase_d;
      stall_q <= stall_d;
      cmd_q <= cmd_d;
      addr_low_q <= addr_low_d;
      addr_high_q <= addr_high_d;
      data_low_q <= data_low_d;
      data_high_q <= data_high_d;
      write_enable_q <= write_enable_d;
      latch_only_q <= latch_only_d;
      erase_q <= erase_d;
      config_space_select_q <= config_space_select_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // ==========================================================
  // flash side: walk the latches while programming
  logic [FSWS_LATCH_BITS-1:0] walk_q, walk_d;
  logic [13:0] ldat_q, ldat_d;

  always_comb begin
    walk_d = cmd_q.prog ? walk_q + 1'b1 : '0; // RULE_07
    ldat_d = cmd_q.prog ? latch_rd : '0;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      walk_q <= '0;
      ldat_q <= '0;
    end else begin
      walk_q <= walk_d;
      ldat_q <= ldat_d;
    end
  end

  assign FLASH_LATCH_IDX = walk_q;
  assign FLASH_LATCH_DATA = ldat_q;
  assign WB_DAT_O = rdat_q;
  assign WB_ACK_O = ack_q;
  assign CPU_STALL = stall_q;
  assign FLASH_ERASE = cmd_q.erase;
  assign FLASH_PROGRAM = cmd_q.prog;
  assign FLASH_ROW = cmd_q.row;

endmodule : fsws_top
`default_nettype wire

// file: hw/fsws_unlock.sv
// Purpose: detects the two-write unlock pattern
// Assumes: acc is a one-cycle pulse per completed bus access
// Notes: armed state is consumed by the next write start
`timescale 1ns/1ns
`default_nettype none
module fsws_unlock
  import fsws_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic acc,
  input wire logic unlock_wr,
  input wire logic [7:0] wdata,
  input wire logic consume,
  output logic armed
);

  logic seen_first_q, seen_first_d;
  logic armed_q, armed_d;

  // ==========================================================
  // pattern tracking
  always_comb begin
    seen_first_d = seen_first_q;
    armed_d = armed_q;
    if (consume) begin
      seen_first_d = 1'b0;
      armed_d = 1'b0;
    end else if (acc) begin
      // any access other than the expected one breaks the pattern
      armed_d = unlock_wr && seen_first_q && wdata == FSWS_UNLOCK_SECOND; // RULE_20
      seen_first_d = unlock_wr && wdata == FSWS_UNLOCK_FIRST; // RULE_13
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      seen_first_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      seen_first_q <= seen_first_d;
      armed_q <= armed_d;
    end
  end

  assign armed = armed_q;

endmodule : fsws_unlock
`default_nettype wire

// file: testbench/fsws_flash_model.sv
// Purpose: behavioural program flash array
// Assumes: latch data lags latch index by one cycle
// Notes: programming only clears bits, as a real cell does
`timescale 1ns/1ns
`default_nettype none
module fsws_flash_model
  import fsws_pkg::*;
(
  input wire logic clk,
  input wire logic erase_en,
  input wire logic prog_en,
  input wire logic [FSWS_ROW_BITS-1:0] row,
  input wire logic [FSWS_LATCH_BITS-1:0] latch_idx,
  input wire logic [13:0] latch_data
);
  logic [13:0] mem [0:32767];
  logic prog_q = 1'b0;
  logic [FSWS_LATCH_BITS-1:0] idx_q;
  initial begin
    foreach (mem[i]) mem[i] = FSWS_BLANK_WORD;
  end
  always @(posedge clk) begin
    if (erase_en) begin
      for (int i = 0; i < FSWS_LATCHES; i++) begin
        mem[{row, i[4:0]}] <= FSWS_BLANK_WORD;
      end
    end
    if (prog_q) begin
      mem[{row, idx_q}] <= mem[{row, idx_q}] & latch_data;
    end
    prog_q <= prog_en;
    idx_q <= latch_idx;
  end
endmodule : fsws_flash_model
`default_nettype wire

// file: testbench/fsws_top_asserts.sv
// Purpose: port assertions for the flash self-write sequencer
// Assumes: RST synchronous, active high
// Notes: bound into fsws_top
`timescale 1ns/1ns
`default_nettype none
module fsws_top_asserts
  import fsws_pkg::*;
#(
  parameter int ERASE_CYCLES = FSWS_ERASE_CYCLES,
  parameter int PROG_CYCLES = FSWS_PROG_CYCLES
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic CPU_STALL,
  input wire logic FLASH_ERASE,
  input wire logic FLASH_PROGRAM,
  input wire logic [FSWS_ROW_BITS-1:0] FLASH_ROW
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // longest op plus setup and clean-up slack
  localparam int STALL_MAX = ((ERASE_CYCLES > PROG_CYCLES) ? ERASE_CYCLES : PROG_CYCLES) + 8;
  logic [31:0] stall_cnt_q;
  logic [31:0] stall_cnt_d;
  always_comb begin
    stall_cnt_d = (RST || !CPU_STALL) ? 32'h0 : stall_cnt_q + 32'h1;
  end
  always_ff @(posedge CLK) begin
    stall_cnt_q <= stall_cnt_d;
  end
  sequence s_req_taken;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_op_end;
    $fell(FLASH_ERASE) || $fell(FLASH_PROGRAM);
  endsequence
  chk_ack_follows: assert property (s_req_taken |=> WB_ACK_O)
    else $error("ack missing after request");
  chk_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  chk_unlock_reads_zero: assert property (
    WB_ACK_O && !$past(WB_WE_I) && $past(WB_ADR_I) == FSWS_UNLOCK_OFS |-> WB_DAT_O == 32'h0)
    else $error("unlock register read not zero");
  chk_setup_first: assert property (
    $rose(FLASH_ERASE || FLASH_PROGRAM) |-> $past(CPU_STALL, 2))
    else $error("array op began without setup cycles");
  chk_busy_stalls: assert property (
    (FLASH_ERASE || FLASH_PROGRAM) |-> CPU_STALL)
    else $error("processor not stalled during array op");
  chk_one_op: assert property (!(FLASH_ERASE && FLASH_PROGRAM))
    else $error("erase and program together");
  chk_row_held: assert property (
    (FLASH_PROGRAM && $past(FLASH_PROGRAM)) || (FLASH_ERASE && $past(FLASH_ERASE))
    |-> $stable(FLASH_ROW))
    else $error("row moved during array op");
  chk_resume_soon: assert property (s_op_end |-> ##[1:4] !CPU_STALL)
    else $error("stall outlived array op");
  chk_stall_bounded: assert property (stall_cnt_q <= STALL_MAX)
    else $error("stall never ended");
endmodule : fsws_top_asserts
bind fsws_top fsws_top_asserts #(.ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES))
  u_fsws_top_asserts (.CLK(CLK), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .CPU_STALL(CPU_STALL), .FLASH_ERASE(FLASH_ERASE), .FLASH_PROGRAM(FLASH_PROGRAM),
  .FLASH_ROW(FLASH_ROW));
`default_nettype wire

// file: testbench/testbench.sv
// Purpose: self-checking bench for the flash self-write sequencer
// Assumes: shortened erase and program timers
// Notes: flash contents are judged in the array model
`timescale 1ns/1ns
`default_nettype none
module testbench
  import fsws_pkg::*;
;
  localparam int ERASE_C = 30;
  localparam int PROG_C = 20;
  localparam logic [7:0] T_ADR [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14, 8'h1c, 8'h10};
  localparam logic [7:0] T_WR [7] = '{8'ha5, 8'h12, 8'h3c, 8'hff, 8'h55, 8'hff, 8'h05};
  // address high always reads its top bit as one
  localparam logic [7:0] T_EXP [7] = '{8'ha5, 8'h92, 8'h3c, 8'h3f, 8'h00, 8'h00, 8'h04};
  localparam logic [13:0] W_EXP [6] = '{14'h2110, 14'h2111, 14'h2112, 14'h3fff, 14'h1233,
    14'h3fff};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack, stall, f_erase, f_prog;
  logic [FSWS_ROW_BITS-1:0] f_row;
  logic [FSWS_LATCH_BITS-1:0] f_idx;
  logic [13:0] f_data;
  int fail_count = 0;
  int checks = 0;
  always #5 clk = ~clk;
  fsws_top #(.ERASE_CYCLES(ERASE_C), .PROG_CYCLES(PROG_C)) u_fsws_top (.CLK(clk), .RST(rst),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .CPU_STALL(stall),
    .FLASH_ERASE(f_erase), .FLASH_PROGRAM(f_prog), .FLASH_ROW(f_row),
    .FLASH_LATCH_IDX(f_idx), .FLASH_LATCH_DATA(f_data));
  fsws_flash_model u_fsws_flash_model (.clk(clk), .erase_en(f_erase), .prog_en(f_prog),
    .row(f_row), .latch_idx(f_idx), .latch_data(f_data));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= {24'h0, d};
    @(posedge clk);
    while (ack !== 1'b1) begin
      @(posedge clk);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 8'h00, q);
  endtask : rd
  task automatic unlock();
    wr(FSWS_UNLOCK_OFS, FSWS_UNLOCK_FIRST);
    wr(FSWS_UNLOCK_OFS, FSWS_UNLOCK_SECOND);
  endtask : unlock
  // counts stall cycles after the start write
  task automatic op(input logic [7:0] ctrl, output int n);
    unlock();
    wr(FSWS_CONTROL_OFS, ctrl);
    n = 0;
    @(posedge clk);
    while (stall === 1'b1) begin
      @(posedge clk);
      n++;
    end
  endtask : op
  initial begin
    #100000;
    fail_count++;
    give_verdict();
  end
  initial begin
    logic [31:0] q;
    int n;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(FSWS_ADDR_HIGH_OFS, q);
    chk("addr high reset", q, 32'h80);
    rd(FSWS_CONTROL_OFS, q);
    // error flag has no defined value at power-up, so it is left out here
    chk("control reset", q & 32'h77, 32'h0);
    for (int i = 0; i < 7; i++) begin
      wr(T_ADR[i], T_WR[i]);
      rd(T_ADR[i], q);
      chk("register", q, {24'h0, T_EXP[i]});
    end
    // ============================================
    // latch loads, broken unlock, program
    wr(FSWS_ADDR_HIGH_OFS, 8'h05);
    wr(FSWS_ADDR_LOW_OFS, 8'h40);
    for (int i = 0; i < 3; i++) begin
      wr(FSWS_DATA_LOW_OFS, 8'(8'h10 + i));
      wr(FSWS_DATA_HIGH_OFS, 8'h21);
      op(8'h25, n);
      chk("load stall short", 32'(n < 4), 32'h1);
      rd(FSWS_CONTROL_OFS, q);
      chk("start cleared", q[FSWS_START_BIT], 1'b0);
      wr(FSWS_ADDR_LOW_OFS, 8'(8'h41 + i));
    end
    wr(FSWS_DATA_LOW_OFS, 8'h00);
    wr(FSWS_DATA_HIGH_OFS, 8'h00);
    wr(FSWS_UNLOCK_OFS, FSWS_UNLOCK_FIRST);
    rd(FSWS_ADDR_LOW_OFS, q);
    wr(FSWS_UNLOCK_OFS, FSWS_UNLOCK_SECOND);
    wr(FSWS_CONTROL_OFS, 8'h25);
    wr(FSWS_ADDR_LOW_OFS, 8'h44);
    wr(FSWS_DATA_LOW_OFS, 8'h33);
    wr(FSWS_DATA_HIGH_OFS, 8'h12);
    op(8'h05, n);
    chk("program stall", 32'(n >= PROG_C), 32'h1);
    for (int i = 0; i < 6; i++) begin
      chk("row word", 32'(u_fsws_flash_model.mem[{10'h02a, 5'(i)}]), 32'(W_EXP[i]));
    end
    // ============================================
    // latches blank again, refused starts, erase
    wr(FSWS_ADDR_LOW_OFS, 8'h65);
    op(8'h05, n);
    chk("blank latch", 32'(u_fsws_flash_model.mem[{10'h02b, 5'd0}]), 32'h3fff);
    chk("loaded latch", 32'(u_fsws_flash_model.mem[{10'h02b, 5'd5}]), 32'h1233);
    op(8'h45, n);
    chk("config select start", n, 0);
    op(8'h01, n);
    chk("no enable start", n, 0);
    wr(FSWS_ADDR_LOW_OFS, 8'h47);
    op(8'h15, n);
    chk("erase stall", 32'(n >= ERASE_C), 32'h1);
    chk("erased word", 32'(u_fsws_flash_model.mem[{10'h02a, 5'd0}]), 32'h3fff);
    chk("other row kept", 32'(u_fsws_flash_model.mem[{10'h02b, 5'd5}]), 32'h1233);
    // ============================================
    // reset in mid-write
    wr(FSWS_CONTROL_OFS, 8'h04);
    unlock();
    wr(FSWS_CONTROL_OFS, 8'h05);
    repeat (6) @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rd(FSWS_CONTROL_OFS, q);
    chk("error flag", q[FSWS_ERR_BIT], 1'b1);
    chk("start after reset", q[FSWS_START_BIT], 1'b0);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
